// ---- hw/linear_code_decode.sv ----
// Maps one linear regulator code to its output setpoint in millivolts.
`timescale 1ns/1ns
module linear_code_decode (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Code in, setpoint out
   input wire logic [7:0] code,
   output logic [11:0] millivolts
);

   pmic_regs_pkg::lin_state_t st_reg;
   pmic_regs_pkg::lin_state_t st_next;
   logic [pmic_regs_pkg::LIN_CODES-1:0] hit;
   logic [5:0] idx;

   // An unlisted code lands on the nearest listed code below it.
   for (genvar i = 0; i < pmic_regs_pkg::LIN_CODES; i++) begin : g_cmp
      assign hit[i] = (code >= pmic_regs_pkg::LIN_TABLE[i]);
   end

   assign idx = 6'($countones(hit)) - 6'h01;

   always_comb begin
      st_next = st_reg;
      st_next.mv = pmic_regs_pkg::LIN_BASE_MV + pmic_regs_pkg::LIN_STEP_MV * {6'h00, idx};
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.mv <= pmic_regs_pkg::LIN_BASE_MV;
      end else begin
         st_reg <= st_next;
      end
   end

   assign millivolts = st_reg.mv;

endmodule : linear_code_decode

// ---- hw/link_sampler.sv ----
// Serial clock domain: samples the data line on each rising serial clock edge.
`timescale 1ns/1ns
module link_sampler (
   // Link side
   input wire logic scl_clk,
   input wire logic sda_level,
   // Core side
   output logic sda_bit
);

   pmic_regs_pkg::link_state_t st_reg;
   pmic_regs_pkg::link_state_t st_next;

   // The serial clock stands still outside frames, so this flop holds plain
   // data only; framing lives in the core domain and needs no reset here.
   always_comb begin
      st_next = st_reg;
      st_next.sda_bit = sda_level;
   end

   always_ff @(posedge scl_clk) begin
      st_reg <= st_next;
   end

   assign sda_bit = st_reg.sda_bit;

endmodule : link_sampler

// ---- hw/pmic_output_voltage_control.sv ----
// Voltage code registers, serial register port, enable pin and fault interrupt.
`timescale 1ns/1ns
module pmic_output_voltage_control (
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Serial register port
   input wire logic scl_clk,
   input wire logic sda_level,
   output logic sda_drive,
   output logic sda_drive_en,
   // Enable pin and analog status
   input wire logic en_pin,
   input wire logic undervoltage_fault,
   input wire logic thermal_fault,
   input wire logic [3:0] output_valid,
   // Fault interrupt pin
   input wire logic fault_irq_out_n_level,
   output logic fault_irq_out_n_drive,
   output logic fault_irq_out_n_drive_en,
   // Regulator control
   output logic [3:0] output_on,
   output logic sequencing_control,
   output logic power_after_fault,
   output logic [11:0] buck_mv,
   output logic [2:0][11:0] lin_mv
);

   pmic_regs_pkg::top_state_t st_reg;
   pmic_regs_pkg::top_state_t st_next;
   logic link_bit;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic bit_evt;
   logic [7:0] rx_byte;
   logic wr_fire;
   logic en_rise;

   // -------------------------------------------------------------------------
   // Link domain and regulator decoders
   // -------------------------------------------------------------------------
   link_sampler u_link (
      .scl_clk(scl_clk),
      .sda_level(sda_level),
      .sda_bit(link_bit)
   );

   for (genvar g = 0; g < 3; g++) begin : g_lin
      linear_code_decode u_dec (
         .ref_clk(ref_clk),
         .nrst(nrst),
         .code(st_reg.lin_code[g]),
         .millivolts(lin_mv[g])
      );
   end

   function automatic logic [7:0] read_reg(input pmic_regs_pkg::top_state_t s,
                                           input logic [2:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == pmic_regs_pkg::ENABLE_ADDR) begin
         d = {2'h0, s.restore, s.seq, s.out_en};
      end else if (a == pmic_regs_pkg::STATUS_ADDR) begin
         d = {1'h0, s.int_en, s.input_undervoltage_flag, s.thermal_shutdown_flag, s.valid_s2};
      end else if (a == pmic_regs_pkg::BUCK_ADDR) begin
         d = s.buck_code;
      end else if (a == pmic_regs_pkg::LIN1_ADDR) begin
         d = s.lin_code[0];
      end else if (a == pmic_regs_pkg::LIN2_ADDR) begin
         d = s.lin_code[1];
      end else if (a == pmic_regs_pkg::LIN3_ADDR) begin
         d = s.lin_code[2];
      end
      return d;
   endfunction : read_reg

   // -------------------------------------------------------------------------
   // Bus events
   // -------------------------------------------------------------------------
   assign scl_rise = st_reg.scl_s2 & ~st_reg.scl_q;
   assign scl_fall = ~st_reg.scl_s2 & st_reg.scl_q;
   assign start_seen = st_reg.scl_s2 & st_reg.scl_q & ~st_reg.sda_s2 & st_reg.sda_q;
   assign stop_seen = st_reg.scl_s2 & st_reg.scl_q & st_reg.sda_s2 & ~st_reg.sda_q;
   // The sampled bit is used only after it has had time to settle through its
   // own synchroniser, which a 400kHz clock leaves ample room for.
   assign bit_evt = st_reg.rise_pipe[pmic_regs_pkg::SETTLE_STAGES-1] &
                    (st_reg.phase != pmic_regs_pkg::PH_IDLE);
   assign rx_byte = {st_reg.shift[6:0], st_reg.bit_s2};
   assign wr_fire = bit_evt & (st_reg.phase == pmic_regs_pkg::PH_WDATA) & (st_reg.cnt == 4'h7);
   assign en_rise = st_reg.en_s2 & ~st_reg.en_q;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.scl_s1 = scl_clk;
      st_next.scl_s2 = st_reg.scl_s1;
      st_next.scl_q = st_reg.scl_s2;
      st_next.sda_s1 = sda_level;
      st_next.sda_s2 = st_reg.sda_s1;
      st_next.sda_q = st_reg.sda_s2;
      st_next.en_s1 = en_pin;
      st_next.en_s2 = st_reg.en_s1;
      st_next.en_q = st_reg.en_s2;
      st_next.bit_s1 = link_bit;
      st_next.bit_s2 = st_reg.bit_s1;
      st_next.fault_s1 = {thermal_fault, undervoltage_fault};
      st_next.fault_s2 = st_reg.fault_s1;
      st_next.valid_s1 = output_valid;
      st_next.valid_s2 = st_reg.valid_s1;
      st_next.rise_pipe = {st_reg.rise_pipe[pmic_regs_pkg::SETTLE_STAGES-2:0], scl_rise};

      // Byte framing: eight data bits, then the acknowledge slot.
      if (bit_evt) begin
         if (st_reg.cnt != 4'h8) begin
            st_next.shift = rx_byte;
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == 4'h7) begin
               if (st_reg.phase == pmic_regs_pkg::PH_ADDR) begin
                  if (rx_byte[7:1] == pmic_regs_pkg::DEV_ADDR) begin
                     st_next.rw = rx_byte[0];
                     st_next.out_byte = read_reg(st_reg, st_reg.ptr);
                  end else begin
                     st_next.phase = pmic_regs_pkg::PH_IDLE;
                  end
               end else if (st_reg.phase == pmic_regs_pkg::PH_REG) begin
                  st_next.ptr = rx_byte[2:0];
               end
            end
         end else begin
            st_next.cnt = 4'h0;
            case (st_reg.phase)
               pmic_regs_pkg::PH_ADDR: begin
                  st_next.phase = st_reg.rw ? pmic_regs_pkg::PH_RDATA : pmic_regs_pkg::PH_REG;
               end
               pmic_regs_pkg::PH_REG: begin
                  st_next.phase = pmic_regs_pkg::PH_WDATA;
               end
               pmic_regs_pkg::PH_WDATA: begin
                  st_next.ptr = st_reg.ptr + 3'h1;
               end
               pmic_regs_pkg::PH_RDATA: begin
                  if (st_reg.bit_s2) begin
                     st_next.phase = pmic_regs_pkg::PH_IDLE;
                  end else begin
                     st_next.ptr = st_reg.ptr + 3'h1;
                     st_next.out_byte = read_reg(st_reg, st_reg.ptr + 3'h1);
                  end
               end
               default: begin
                  st_next.phase = pmic_regs_pkg::PH_IDLE;
               end
            endcase
         end
      end

      // The data line changes just after a falling serial clock; a start or stop also releases it.
      if (scl_fall) begin
         st_next.sda_low = 1'h0;
         if (st_reg.phase == pmic_regs_pkg::PH_RDATA) begin
            if (st_reg.cnt != 4'h8) begin
               st_next.sda_low = ~st_reg.out_byte[3'h7 - st_reg.cnt[2:0]];
            end
         end else if (st_reg.phase != pmic_regs_pkg::PH_IDLE && st_reg.cnt == 4'h8) begin
            st_next.sda_low = 1'h1;
         end
      end

      if (start_seen || stop_seen) begin
         st_next.phase = start_seen ? pmic_regs_pkg::PH_ADDR : pmic_regs_pkg::PH_IDLE;
         st_next.cnt = 4'h0;
         st_next.sda_low = 1'h0;
         st_next.rise_pipe = '0;
      end

      // Register writes.
      if (wr_fire) begin
         if (st_reg.ptr == pmic_regs_pkg::ENABLE_ADDR) begin
            st_next.restore = rx_byte[pmic_regs_pkg::EN_RESTORE_POS];
            st_next.seq = rx_byte[pmic_regs_pkg::EN_SEQ_POS];
            st_next.out_en = rx_byte[3:0];
         end else if (st_reg.ptr == pmic_regs_pkg::STATUS_ADDR) begin
            st_next.int_en = rx_byte[pmic_regs_pkg::ST_INT_EN_POS];
            if (rx_byte[pmic_regs_pkg::ST_UNDERVOLTAGE_POS]) begin
               st_next.input_undervoltage_flag = 1'h0;
            end
            if (rx_byte[pmic_regs_pkg::ST_THERMAL_POS]) begin
               st_next.thermal_shutdown_flag = 1'h0;
            end
         end else if (st_reg.ptr == pmic_regs_pkg::BUCK_ADDR) begin
            st_next.buck_code = rx_byte;
         end else if (st_reg.ptr == pmic_regs_pkg::LIN1_ADDR) begin
            st_next.lin_code[0] = rx_byte;
         end else if (st_reg.ptr == pmic_regs_pkg::LIN2_ADDR) begin
            st_next.lin_code[1] = rx_byte;
         end else if (st_reg.ptr == pmic_regs_pkg::LIN3_ADDR) begin
            st_next.lin_code[2] = rx_byte;
         end
      end

      // A live fault sets its flag again even in the cycle of its clear.
      if (st_reg.fault_s2[0]) begin
         st_next.input_undervoltage_flag = 1'h1;
      end
      if (st_reg.fault_s2[1]) begin
         st_next.thermal_shutdown_flag = 1'h1;
      end
      st_next.irq_low = st_next.int_en &
                        (st_next.input_undervoltage_flag | st_next.thermal_shutdown_flag);

      // A startup edge overrides a write landing in the same cycle.
      if (en_rise) begin
         st_next.seq = pmic_regs_pkg::STARTUP_SEQ;
         st_next.out_en = pmic_regs_pkg::STARTUP_OUT_EN;
      end
      st_next.output_on = st_next.out_en & {4{st_reg.en_s2}};

      if (st_reg.buck_code < pmic_regs_pkg::BUCK_COARSE_FIRST) begin
         st_next.buck_mv = pmic_regs_pkg::BUCK_BASE_MV +
                           pmic_regs_pkg::BUCK_FINE_STEP_MV * {4'h0, st_reg.buck_code};
      end else begin
         st_next.buck_mv = pmic_regs_pkg::BUCK_COARSE_BASE_MV +
                           pmic_regs_pkg::BUCK_COARSE_STEP_MV *
                           {4'h0, st_reg.buck_code - pmic_regs_pkg::BUCK_COARSE_FIRST};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.phase <= pmic_regs_pkg::PH_IDLE;
         st_reg.restore <= pmic_regs_pkg::RESTORE_RESET;
         st_reg.seq <= pmic_regs_pkg::SEQ_RESET;
         st_reg.out_en <= pmic_regs_pkg::OUT_EN_RESET;
         st_reg.int_en <= pmic_regs_pkg::INT_EN_RESET;
         st_reg.buck_code <= pmic_regs_pkg::BUCK_CODE_RESET;
         st_reg.lin_code <= {3{pmic_regs_pkg::LIN_CODE_RESET}};
         st_reg.buck_mv <= pmic_regs_pkg::BUCK_BASE_MV;
      end else begin
         st_reg <= st_next;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign sda_drive = 1'h0;
   assign sda_drive_en = st_reg.sda_low;
   assign fault_irq_out_n_drive = 1'h0;
   assign fault_irq_out_n_drive_en = st_reg.irq_low;
   assign output_on = st_reg.output_on;
   assign sequencing_control = st_reg.seq;
   assign power_after_fault = st_reg.restore;
   assign buck_mv = st_reg.buck_mv;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_buck_write_lands: assert property (
      (wr_fire && st_reg.ptr == 3'h2) |=> st_reg.buck_code == $past(rx_byte))
      else $error("buck code write lost");
   a_buck_top_code: assert property (
      (st_reg.buck_code == 8'h1c)[*2] |-> st_reg.buck_mv == 12'h708)
      else $error("buck code 1c is not 1800 mV");
   a_buck_fine_end: assert property (
      (st_reg.buck_code == 8'h0f)[*2] |-> st_reg.buck_mv == 12'h497)
      else $error("buck code 0f is not 1175 mV");
   a_lin_write_order: assert property (
      (wr_fire && st_reg.ptr == 3'h5) |=> st_reg.lin_code[2] == $past(rx_byte))
      else $error("third linear code write lost");
   a_lin_top_code: assert property (
      (st_reg.lin_code[1] == 8'he8)[*2] |-> lin_mv[1] == 12'hce4)
      else $error("linear code e8 is not 3300 mV");
   a_lin_live_update: assert property (
      (wr_fire && st_reg.ptr == 3'h3 && rx_byte == 8'h0b && st_reg.output_on[1])
      |-> ##2 lin_mv[0] == 12'h352)
      else $error("linear code not applied while on");
   a_outputs_gated: assert property (
      !st_reg.en_s2 |=> st_reg.output_on == 4'h0)
      else $error("output on without enable pin");
   a_level_no_reload: assert property (
      (st_reg.en_s2 && st_reg.en_q && wr_fire && st_reg.ptr == 3'h0)
      |=> st_reg.out_en == $past(rx_byte[3:0]))
      else $error("steady enable level reloaded defaults");
   a_irq_two_sources: assert property (
      fault_irq_out_n_drive_en |->
      (st_reg.input_undervoltage_flag || st_reg.thermal_shutdown_flag) && st_reg.int_en)
      else $error("interrupt without fault source");
   a_irq_follows_fault: assert property (
      (st_reg.int_en && st_reg.fault_s2 != 2'h0 && !wr_fire) |=> fault_irq_out_n_drive_en)
      else $error("interrupt missing during fault");
   a_sda_idle_free: assert property (
      (st_reg.phase == pmic_regs_pkg::PH_IDLE)[*2] |-> !sda_drive_en)
      else $error("data line driven while idle");
   a_startup_reload: assert property (
      en_rise |=> st_reg.out_en == 4'hf && st_reg.seq == 1'h0)
      else $error("startup did not reload defaults");
   a_flag_set_wins: assert property (
      st_reg.fault_s2[0] |=> st_reg.input_undervoltage_flag)
      else $error("undervoltage flag lost while fault active");
   a_int_en_write: assert property (
      (wr_fire && st_reg.ptr == 3'h1) |=> st_reg.int_en == $past(rx_byte[6]))
      else $error("interrupt enable write lost");

endmodule : pmic_output_voltage_control

// ---- hw/pmic_regs_pkg.sv ----
// Shared constants, register map and types of the regulator voltage control block.
package pmic_regs_pkg;

   // -------------------------------------------------------------------------
   // Register map, lower three bits of the received register address
   // -------------------------------------------------------------------------
   localparam logic [2:0] ENABLE_ADDR = 3'h0;
   localparam logic [2:0] STATUS_ADDR = 3'h1;
   localparam logic [2:0] BUCK_ADDR = 3'h2;
   localparam logic [2:0] LIN1_ADDR = 3'h3;
   localparam logic [2:0] LIN2_ADDR = 3'h4;
   localparam logic [2:0] LIN3_ADDR = 3'h5;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int EN_RESTORE_POS = 5;
   localparam int EN_SEQ_POS = 4;
   localparam int ST_INT_EN_POS = 6;
   localparam int ST_UNDERVOLTAGE_POS = 5;
   localparam int ST_THERMAL_POS = 4;

   // -------------------------------------------------------------------------
   // Reset and startup values
   // -------------------------------------------------------------------------
   localparam logic RESTORE_RESET = 1'h1;
   localparam logic SEQ_RESET = 1'h0;
   localparam logic [3:0] OUT_EN_RESET = 4'h0;
   localparam logic INT_EN_RESET = 1'h0;
   localparam logic [7:0] BUCK_CODE_RESET = 8'h00;
   localparam logic [7:0] LIN_CODE_RESET = 8'h00;
   localparam logic STARTUP_SEQ = 1'h0;
   localparam logic [3:0] STARTUP_OUT_EN = 4'hf;
   // Serial bus device address; the value is arbitrary.
   localparam logic [6:0] DEV_ADDR = 7'h4c;

   // -------------------------------------------------------------------------
   // Timing: ref_clk cycles between a seen clock rise and use of the sampled bit
   // -------------------------------------------------------------------------
   localparam int SETTLE_STAGES = 2;

   // -------------------------------------------------------------------------
   // Voltage scales in millivolts
   // -------------------------------------------------------------------------
   localparam logic [7:0] BUCK_COARSE_FIRST = 8'h10;
   localparam logic [11:0] BUCK_BASE_MV = 12'h320;
   localparam logic [11:0] BUCK_FINE_STEP_MV = 12'h019;
   localparam logic [11:0] BUCK_COARSE_BASE_MV = 12'h4b0;
   localparam logic [11:0] BUCK_COARSE_STEP_MV = 12'h032;
   localparam logic [11:0] LIN_BASE_MV = 12'h320;
   localparam logic [11:0] LIN_STEP_MV = 12'h032;
   localparam int LIN_CODES = 51;
   localparam logic [7:0] LIN_TABLE [LIN_CODES] = '{
      8'h00, 8'h0b, 8'h14, 8'h1d, 8'h25, 8'h2e, 8'h37, 8'h3e, 8'h45, 8'h4c,
      8'h52, 8'h57, 8'h5c, 8'h61, 8'h65, 8'h69, 8'h6d, 8'h72, 8'h79, 8'h7f,
      8'h85, 8'h8b, 8'h91, 8'h96, 8'h9a, 8'h9f, 8'ha4, 8'ha8, 8'hac, 8'hb0,
      8'hb4, 8'hb7, 8'hba, 8'hbd, 8'hc1, 8'hc4, 8'hc7, 8'hc9, 8'hcc, 8'hce,
      8'hd1, 8'hd3, 8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde, 8'he1, 8'he3, 8'he6,
      8'he8};

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_REG = 3'b010,
      PH_WDATA = 3'b011,
      PH_RDATA = 3'b100
   } phase_t;

   typedef struct packed {
      logic sda_bit;
   } link_state_t;

   typedef struct packed {
      logic [11:0] mv;
   } lin_state_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_q;
      logic sda_s1;
      logic sda_s2;
      logic sda_q;
      logic en_s1;
      logic en_s2;
      logic en_q;
      logic bit_s1;
      logic bit_s2;
      logic [1:0] fault_s1;
      logic [1:0] fault_s2;
      logic [3:0] valid_s1;
      logic [3:0] valid_s2;
      logic [SETTLE_STAGES-1:0] rise_pipe;
      phase_t phase;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic rw;
      logic [2:0] ptr;
      logic [7:0] out_byte;
      logic sda_low;
      logic irq_low;
      logic restore;
      logic seq;
      logic [3:0] out_en;
      logic [3:0] output_on;
      logic int_en;
      logic input_undervoltage_flag;
      logic thermal_shutdown_flag;
      logic [7:0] buck_code;
      logic [2:0][7:0] lin_code;
      logic [11:0] buck_mv;
   } top_state_t;

endpackage : pmic_regs_pkg

// ---- verification/host_i2c_model.sv ----
// Host model: serial bus master on a pulled-up data wire.
`timescale 1ns/1ns
module host_i2c_model (
   // Device side
   input wire logic dev_pull,
   input wire logic dev_level,
   // Bus wires
   output logic scl,
   output logic sda
);
   // A quarter of a 2560 ns bit keeps edges on the core clock's falling edges.
   localparam int Q = 640;
   logic host_low = 1'b0;
   // The wire is pulled up; a device that pulls it shows the value that it drives.
   assign sda = ~host_low & (~dev_pull | dev_level);
   initial begin
      scl = 1'b1;
   end
   task automatic clk_bit(input logic b, output logic s);
      host_low = ~b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
      #Q;
   endtask : clk_bit
   task automatic start;
      host_low = 1'b0;
      #Q scl = 1'b1;
      #Q host_low = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask : start
   task automatic stop;
      host_low = 1'b1;
      #Q scl = 1'b1;
      #Q host_low = 1'b0;
      #(2 * Q);
   endtask : stop
   task automatic byte_tx(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask : byte_tx
   task automatic write_reg(input logic [7:0] r, input logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      byte_tx({pmic_regs_pkg::DEV_ADDR, 1'b0}, a0);
      byte_tx(r, a1);
      byte_tx(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] r, output logic [7:0] d);
      logic a, s;
      start();
      byte_tx({pmic_regs_pkg::DEV_ADDR, 1'b0}, a);
      byte_tx(r, a);
      start();
      byte_tx({pmic_regs_pkg::DEV_ADDR, 1'b1}, a);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, s);
      stop();
   endtask : read_reg
endmodule : host_i2c_model

// ---- verification/pmic_output_voltage_control_bench.sv ----
// Self-checking bench of the voltage code registers and their pins.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module pmic_output_voltage_control_bench;
   logic ref_clk, nrst, scl, sda, en_pin, uv_fault, hot_fault, ok;
   logic sda_en, sda_drv, irq_en, irq_drv, seq, restore;
   logic [3:0] valid, on;
   logic [11:0] buck_mv;
   logic [2:0][11:0] lin_mv;
   logic [7:0] code, rd;
   logic [7:0] corner [3] = '{8'h0f, 8'h10, 8'h1c};
   int n_errors = 0, n_compared = 0, seed = 56, idx;
   host_i2c_model host_i2c_model_i (.dev_pull(sda_en), .dev_level(sda_drv), .scl(scl), .sda(sda));
   pmic_output_voltage_control pmic_output_voltage_control_i (
      .ref_clk(ref_clk), .nrst(nrst), .scl_clk(scl), .sda_level(sda), .sda_drive(sda_drv),
      .sda_drive_en(sda_en), .en_pin(en_pin), .undervoltage_fault(uv_fault),
      .thermal_fault(hot_fault), .output_valid(valid), .fault_irq_out_n_level(~irq_en),
      .fault_irq_out_n_drive(irq_drv), .fault_irq_out_n_drive_en(irq_en), .output_on(on),
      .sequencing_control(seq), .power_after_fault(restore), .buck_mv(buck_mv), .lin_mv(lin_mv));
   // ------------------
   // Helpers
   // ------------------
   function automatic logic [11:0] buck_exp(input logic [7:0] c);
      return (c < 8'h10) ? 12'h320 + 12'(c) * 12'h019 : 12'h4b0 + 12'(c - 8'h10) * 12'h032;
   endfunction : buck_exp
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      host_i2c_model_i.write_reg(r, d, ok);
      `CHK(ok, 1'b1)
   endtask : wr
   task automatic give_verdict;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Fourteen writes and three reads take about 1.34 ms.
   initial begin
      #1900000;
      n_errors++;
      give_verdict();
   end
   initial begin
      nrst = 1'b0;
      en_pin = 1'b0;
      uv_fault = 1'b0;
      hot_fault = 1'b0;
      valid = 4'h0;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (12) @(negedge ref_clk);
      `CHK(buck_mv, 12'h320)
      `CHK(lin_mv, {3{12'h320}})
      `CHK(restore, 1'b1)
      `CHK(sda_drv, 1'b0)
      `CHK(irq_drv, 1'b0)
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         code = (i < 3) ? corner[i] : 8'({$random(seed)} % 29);
         valid = 4'($random(seed));
         wr({5'($random(seed)), 3'h2}, code);
         `CHK(buck_mv, buck_exp(code))
      end
      host_i2c_model_i.read_reg(8'h02, rd);
      `CHK(rd, code)
      $display("test buck done");
      en_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK(on, 4'hf)
      `CHK(seq, 1'b0)
      for (int k = 0; k < 3; k++) begin
         // The first two codes are the corners that the live-update and top-code checks wait for.
         idx = (k == 0) ? 1 : (k == 1) ? 50 : {$random(seed)} % 51;
         wr(8'h03 + 8'(k), pmic_regs_pkg::LIN_TABLE[idx]);
         `CHK(lin_mv[k], 12'h320 + 12'(idx) * 12'h032)
      end
      `CHK(on, 4'hf)
      wr(8'h00, 8'h03);
      `CHK(on, 4'h3)
      en_pin = 1'b0;
      repeat (8) @(negedge ref_clk);
      `CHK(on, 4'h0)
      en_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK(on, 4'hf)
      $display("test enable done");
      uv_fault = 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK(irq_en, 1'b0)
      wr(8'h01, 8'h40);
      `CHK(irq_en, 1'b1)
      `CHK(irq_drv, 1'b0)
      wr(8'h01, 8'h60);
      `CHK(irq_en, 1'b1)
      uv_fault = 1'b0;
      hot_fault = 1'b1;
      wr(8'h01, 8'h60);
      `CHK(irq_en, 1'b1)
      hot_fault = 1'b0;
      wr(8'h01, 8'h50);
      `CHK(irq_en, 1'b0)
      host_i2c_model_i.read_reg(8'h06, rd);
      `CHK(rd, 8'h00)
      host_i2c_model_i.read_reg(8'h01, rd);
      `CHK(rd, {4'h4, valid})
      $display("test fault done");
      give_verdict();
   end
endmodule : pmic_output_voltage_control_bench
